// *** dv/sync_conditioning_video_source_tb.sv ***
`timescale 1ns/1ps
module sync_conditioning_video_source_tb;
    import sync_video_pkg::*;

    // Stimulus and observed signals
    logic                  clock, srst, sync_in, genlock_in, ok;
    logic                  ext_sync_delay_enable, ext_sync_rising_edge, integrate_then_read, read_delay_enable;
    logic                  genlock_enable, display_clock_genlock, sensor_array_valid, video_ready;
    logic [DELAY_US_W-1:0] ext_sync_delay_us, read_delay_us, genlock_delay_us;
    logic [1:0]            video_source;
    logic [PIXEL_W-1:0]    constant_value, sensor_array_data, video_data, ramp;
    logic                  sensor_array_ready, video_valid, ext_sync_act, read_start, genlock_act;
    logic                  video_clock_strobe, ext_sync_pending, genlock_pending;
    // Bookkeeping
    int                    errors, num_checks, seed, n;
    int                    cyc = 0;
    logic [31:0]           pq[$];
    logic [31:0]           vq[$];

    // Clock, 20 ns period
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    sync_source_model sync_source_model_i (.clock(clock), .sync_in(sync_in), .genlock_in(genlock_in));

    sync_conditioning_video_source sync_conditioning_video_source_i
    (
        .clock(clock), .srst(srst), .sync_in(sync_in), .genlock_in(genlock_in),
        .ext_sync_delay_enable(ext_sync_delay_enable), .ext_sync_rising_edge(ext_sync_rising_edge),
        .ext_sync_delay_us(ext_sync_delay_us), .integrate_then_read(integrate_then_read),
        .read_delay_enable(read_delay_enable), .read_delay_us(read_delay_us), .genlock_enable(genlock_enable),
        .genlock_delay_us(genlock_delay_us), .display_clock_genlock(display_clock_genlock),
        .video_source(video_source), .constant_value(constant_value),
        .sensor_array_valid(sensor_array_valid), .sensor_array_data(sensor_array_data),
        .sensor_array_ready(sensor_array_ready), .video_valid(video_valid), .video_data(video_data),
        .video_ready(video_ready), .ext_sync_act(ext_sync_act), .read_start(read_start),
        .genlock_act(genlock_act), .video_clock_strobe(video_clock_strobe),
        .ext_sync_pending(ext_sync_pending), .genlock_pending(genlock_pending)
    );

    // Compare one value against its expectation
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Edge counter shared by drivers and monitors
    always @(posedge clock)
        cyc <= cyc + 1;

    // Each action pulse must match the oldest noted kind and cycle
    always
    begin
        @(posedge clock);
        #1;
        if (ext_sync_act === 1'b1) check({8'h00, 24'(cyc)}, pq.size() ? pq.pop_front() : 32'hFFFF_FFFF);
        if (read_start === 1'b1) check({8'h01, 24'(cyc)}, pq.size() ? pq.pop_front() : 32'hFFFF_FFFF);
        if (genlock_act === 1'b1) check({8'h02, 24'(cyc)}, pq.size() ? pq.pop_front() : 32'hFFFF_FFFF);
    end

    // Each delivered pixel must match the oldest noted pixel
    always @(posedge clock)
        if (video_valid === 1'b1 && video_ready === 1'b1)
            check(32'(video_data), vq.size() ? vq.pop_front() : 32'hFFFF_FFFF);

    // Sync edge with the cycles of action and start it should cause
    task automatic sync_edge(input logic level, input int ext_off, input int read_off);
        sync_source_model_i.set_sync(level);
        if (ext_off > 0) pq.push_back({8'h00, 24'(cyc + ext_off)});
        if (read_off > 0) pq.push_back({8'h01, 24'(cyc + read_off)});
        @(posedge clock);
        #1;
        check(ext_sync_pending, 32'(read_off > 1));
        repeat (70) @(posedge clock);
    endtask

    // Genlock pulse with the cycle of action it should cause
    task automatic genlock_edge(input int gen_off);
        sync_source_model_i.set_genlock(1'b1);
        if (gen_off > 0) pq.push_back({8'h02, 24'(cyc + gen_off)});
        @(posedge clock);
        #1;
        check(genlock_pending, 32'(gen_off > 0));
        repeat (3) @(posedge clock);
        sync_source_model_i.set_genlock(1'b0);
        repeat (120) @(posedge clock);
    endtask

    // Offer one pixel; note what should come out if it is taken
    task automatic send_pix(input logic [1:0] src, output logic taken);
        @(negedge clock);
        video_source       = src;
        sensor_array_valid = 1'b1;
        sensor_array_data  = PIXEL_W'($random(seed));
        #1;
        taken = sensor_array_ready;
        if (taken === 1'b1)
        begin
            if (src == SRC_SENSOR) vq.push_back(32'(sensor_array_data));
            else if (src == SRC_RAMP) vq.push_back(32'(ramp++));
            else vq.push_back(32'(constant_value));
        end
    endtask

    // Count video clock strobes over 40 cycles, one genlock pulse inside
    task automatic count_strobes(input logic gen_sel, input int exp);
        int cnt;
        cnt = 0;
        @(negedge clock);
        display_clock_genlock = gen_sel;
        repeat (4) @(posedge clock);
        for (int i = 0; i < 40; i++)
        begin
            if (i == 10) sync_source_model_i.set_genlock(1'b1);
            if (i == 14) sync_source_model_i.set_genlock(1'b0);
            @(posedge clock);
            #1;
            cnt += int'(video_clock_strobe === 1'b1);
        end
        check(cnt, exp);
    endtask

    // Stop the buffer feed and wait until noted pixels are out
    task automatic drain(input logic stall);
        @(negedge clock);
        sensor_array_valid = 1'b0;
        for (int i = 0; i < 600 && vq.size() > 0; i++)
            @(negedge clock) video_ready = stall ? 1'($random(seed)) : 1'b1;
        check(vq.size(), 0);
    endtask

    // Watchdog
    initial
    begin
        #1_000_000;
        errors++;
        wrap_up();
    end

    // Main sequence
    initial
    begin
        {errors, num_checks, seed, ramp} = {32'h0, 32'h0, 32'h9, 14'h0000};
        {srst, integrate_then_read, ext_sync_rising_edge, video_ready} = 4'hF;
        {ext_sync_delay_enable, read_delay_enable, genlock_enable, display_clock_genlock} = 4'h0;
        {ext_sync_delay_us, read_delay_us, genlock_delay_us} = '0;
        {video_source, sensor_array_valid, sensor_array_data} = '0;
        constant_value = PIXEL_W'($random(seed));
        repeat (20) @(posedge clock);
        @(negedge clock) srst = 1'b0;
        @(posedge clock);
        #1;
        check({ext_sync_pending, genlock_pending, video_valid, sensor_array_ready}, 32'h0000_0001);
        // External sync: rising edges only, then falling edges with a delay
        sync_edge(1'b1, 1, 1);
        sync_edge(1'b0, 0, 0);
        @(negedge clock) {ext_sync_rising_edge, ext_sync_delay_enable, ext_sync_delay_us} = {2'b01, 16'h0001};
        sync_edge(1'b1, 0, 0);
        sync_edge(1'b0, 52, 52);
        // Start delayed after an undelayed sync action
        @(negedge clock) {ext_sync_rising_edge, ext_sync_delay_enable, read_delay_enable} = 3'b101;
        read_delay_us = 16'h0001;
        sync_edge(1'b1, 1, 52);
        // Outside integrate-then-read no edge is acted on
        @(negedge clock) integrate_then_read = 1'b0;
        sync_edge(1'b0, 0, 0);
        sync_edge(1'b1, 0, 0);
        // Genlock delay cannot be skipped, even at zero
        @(negedge clock) genlock_enable = 1'b1;
        genlock_edge(2);
        @(negedge clock) genlock_delay_us = 16'h0002;
        genlock_edge(102);
        // Video clock from the divider, then from genlock with the lock path off
        count_strobes(1'b0, 40 / VIDEO_DIV);
        @(negedge clock) genlock_enable = 1'b0;
        count_strobes(1'b1, 1);
        // Every source code, then fill with output stalled until refused
        for (int s = 0; s < 4; s++)
            repeat (4) send_pix(2'(s), ok);
        drain(1'b0);
        @(negedge clock) video_ready = 1'b0;
        n = 0;
        ok = 1'b1;
        while (ok === 1'b1 && n < 40)
        begin
            send_pix(2'($random(seed)), ok);
            n += int'(ok === 1'b1);
        end
        check(n, FIFO_DEPTH + 1);
        drain(1'b1);
        // Ramp across full scale and back through zero, output never stalled
        @(negedge clock) video_ready = 1'b1;
        repeat (16390) send_pix(SRC_RAMP, ok);
        drain(1'b0);
        check(pq.size(), 0);
        wrap_up();
    end
endmodule

// *** dv/sync_source_model.sv ***
`timescale 1ns/1ps
// Stand-in for the external sync source and the genlock composite sync
module sync_source_model
(
    // Clock
    input  wire logic clock,
    // Sync pins
    output logic      sync_in,
    output logic      genlock_in
);
    // Both lines rest low until a scenario moves them
    initial
    begin
        sync_in    = 1'b0;
        genlock_in = 1'b0;
    end

    // Sync level moves just after a falling edge
    task automatic set_sync(input logic level);
        @(negedge clock);
        sync_in = level;
    endtask

    // Genlock level moves just after a falling edge
    task automatic set_genlock(input logic level);
        @(negedge clock);
        genlock_in = level;
    endtask
endmodule

// *** include/pixel_fifo_if.sv ***
`timescale 1ns/1ps
// Pixel stream between the source mux and the buffer
interface pixel_fifo_if #(parameter int WIDTH = 14);
    logic [WIDTH-1:0] wdata;
    logic             wvalid;
    logic             wready;
    logic [WIDTH-1:0] rdata;
    logic             rvalid;
    logic             rready;

    // Filling side
    modport source (output wdata, output wvalid, input wready);
    // Buffer itself
    modport store (input wdata, input wvalid, input rready, output wready, output rdata, output rvalid);
    // Draining side
    modport drain (input rdata, input rvalid, output rready);
endinterface

// *** include/sync_video_pkg.sv ***
// Operation
// (RULE_01) Optional programmed delay before acting on sync
// (RULE_02) Sync registered on selectable rising/falling edge
// (RULE_03) Genlock runs only while enabled
// (RULE_04) Genlock always applies programmed delay
// (RULE_05) Optional programmed delay in integrate-then-read
// (RULE_06) Video clock from master or genlock
// (RULE_07) Video from sensor, ramp or constant
// (RULE_08) External sync honoured only in integrate-then-read
// (RULE_09) Ramp steps per pixel; constant is programmed
package sync_video_pkg;

    // Clock and delay arithmetic
    localparam int CLOCK_PERIOD_NS = 20;
    localparam int NS_PER_US       = 1000;
    localparam int DELAY_US_W      = 16;
    localparam int COUNT_W         = 22;
    localparam int STEP            = 1;
    localparam logic [COUNT_W-1:0] CYCLES_PER_US = COUNT_W'(NS_PER_US / CLOCK_PERIOD_NS);
    localparam logic [COUNT_W-1:0] COUNT_ZERO    = '0;
    localparam logic [COUNT_W-1:0] COUNT_ONE     = COUNT_W'(STEP);

    // Video path sizing
    localparam int PIXEL_W    = 14;
    localparam int FIFO_DEPTH = 32;
    localparam int VIDEO_DIV  = 2;

    // Video source select codes; 2'b11 has no name and selects the constant like SRC_CONSTANT
    typedef enum logic [1:0]
    {
        SRC_SENSOR   = 2'b00,
        SRC_RAMP     = 2'b01,
        SRC_CONSTANT = 2'b10
    } source_t;

    // External sync sequencer states
    typedef enum logic [1:0]
    {
        EXT_IDLE  = 2'b00,
        EXT_WAIT  = 2'b01,
        READ_WAIT = 2'b10
    } ext_state_t;

    // Microseconds to clock cycles
    function automatic logic [COUNT_W-1:0] us_to_cycles(input logic [DELAY_US_W-1:0] us);
        return COUNT_W'(us) * CYCLES_PER_US;
    endfunction

endpackage

// *** rtl/pixel_fifo.sv ***
`timescale 1ns/1ps
module pixel_fifo
#(
    parameter int WIDTH = 14,
    parameter int DEPTH = 32
)
(
    // Clock and reset
    input wire logic   clock,
    input wire logic   srst,
    // Stream
    pixel_fifo_if.store bus
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W-1:0] PTR_ONE  = PTR_W'(1);
    localparam logic [PTR_W:0]   CNT_ONE  = (PTR_W+1)'(1);
    localparam logic [PTR_W:0]   CNT_FULL = (PTR_W+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0]            wr_ptr;
        logic [PTR_W-1:0]            rd_ptr;
        logic [PTR_W:0]              count;
        logic [WIDTH-1:0]            rdata;
        logic                        rvalid;
    } fifo_state_t;

    fifo_state_t state;
    fifo_state_t next_state;
    logic        push;
    logic        load;
    logic        pop;
    logic        store;

    // Handshake and registered head word
    assign bus.wready = (state.count != CNT_FULL);
    assign bus.rdata  = state.rdata;
    assign bus.rvalid = state.rvalid;

    // Output stage refills from memory, or bypasses when memory is empty
    always_comb
    begin
        next_state = state;
        push  = bus.wvalid && bus.wready;
        load  = !state.rvalid || bus.rready;
        pop   = load && (state.count != '0);
        store = push && (!load || pop);
        if (load)
        begin
            next_state.rvalid = pop || push;
        end
        if (pop)
        begin
            next_state.rdata  = state.mem[state.rd_ptr];
            next_state.rd_ptr = state.rd_ptr + PTR_ONE;
        end
        else if (load && push)
        begin
            next_state.rdata = bus.wdata;
        end
        if (store)
        begin
            next_state.mem[state.wr_ptr] = bus.wdata;
            next_state.wr_ptr = state.wr_ptr + PTR_ONE;
        end
        if (store && !pop)
        begin
            next_state.count = state.count + CNT_ONE;
        end
        else if (!store && pop)
        begin
            next_state.count = state.count - CNT_ONE;
        end
    end

    // State register
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end
endmodule

// *** rtl/sync_conditioning_video_source.sv ***
`timescale 1ns/1ps
module sync_conditioning_video_source
    import sync_video_pkg::*;
#(
    parameter int PIXEL_WIDTH  = PIXEL_W,
    parameter int BUFFER_DEPTH = FIFO_DEPTH,
    parameter int MASTER_DIV   = VIDEO_DIV
)
(
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   srst,
    // Sync pins
    input  wire logic                   sync_in,
    input  wire logic                   genlock_in,
    // External sync controls
    input  wire logic                   ext_sync_delay_enable,
    input  wire logic                   ext_sync_rising_edge,
    input  wire logic [DELAY_US_W-1:0]  ext_sync_delay_us,
    // Integration controls
    input  wire logic                   integrate_then_read,
    input  wire logic                   read_delay_enable,
    input  wire logic [DELAY_US_W-1:0]  read_delay_us,
    // Genlock controls
    input  wire logic                   genlock_enable,
    input  wire logic [DELAY_US_W-1:0]  genlock_delay_us,
    // Video controls
    input  wire logic                   display_clock_genlock,
    input  wire logic [1:0]             video_source,
    input  wire logic [PIXEL_WIDTH-1:0] constant_value,
    // Sensor array pixels
    input  wire logic                   sensor_array_valid,
    input  wire logic [PIXEL_WIDTH-1:0] sensor_array_data,
    output wire logic                   sensor_array_ready,
    // Video output
    output wire logic                   video_valid,
    output wire logic [PIXEL_WIDTH-1:0] video_data,
    input  wire logic                   video_ready,
    // Sync actions and status
    output wire logic                   ext_sync_act,
    output wire logic                   read_start,
    output wire logic                   genlock_act,
    output wire logic                   video_clock_strobe,
    output wire logic                   ext_sync_pending,
    output wire logic                   genlock_pending
);
    localparam int DIV_W = (MASTER_DIV > 2) ? $clog2(MASTER_DIV) : 1;
    localparam logic [DIV_W-1:0]       DIV_LAST = DIV_W'(MASTER_DIV - STEP);
    localparam logic [DIV_W-1:0]       DIV_ONE  = DIV_W'(STEP);
    localparam logic [PIXEL_WIDTH-1:0] RAMP_ONE = PIXEL_WIDTH'(STEP);

    typedef struct packed {
        ext_state_t             ext_state;
        logic [COUNT_W-1:0]     ext_count;
        logic                   gl_busy;
        logic [COUNT_W-1:0]     gl_count;
        logic                   sync_prev;
        logic                   gl_prev;
        logic [PIXEL_WIDTH-1:0] ramp;
        logic [DIV_W-1:0]       div_count;
        logic                   ext_act;
        logic                   read_act;
        logic                   gl_act;
        logic                   strobe;
    } state_t;

    state_t                 state;
    state_t                 next_state;
    logic                   sync_edge;
    logic                   gl_edge;
    logic                   ext_fire;
    logic                   master_tick;
    logic                   push;
    logic [PIXEL_WIDTH-1:0] pixel_mux;
    logic [COUNT_W-1:0]     ext_cycles;
    logic [COUNT_W-1:0]     read_cycles;
    logic [COUNT_W-1:0]     gl_cycles;

    pixel_fifo_if #(.WIDTH(PIXEL_WIDTH)) fifo ();

    // Buffer in the video path
    pixel_fifo #(
        .WIDTH (PIXEL_WIDTH),
        .DEPTH (BUFFER_DEPTH)
    ) u_buffer (
        .clock (clock),
        .srst  (srst),
        .bus   (fifo)
    );

    // Programmed delays in cycles
    assign ext_cycles = us_to_cycles(ext_sync_delay_us);
    assign read_cycles = us_to_cycles(read_delay_us);
    assign gl_cycles  = us_to_cycles(genlock_delay_us);

    // Stream hookup; sensor pixels pace every source
    assign push               = sensor_array_valid && fifo.wready;
    assign fifo.wvalid        = sensor_array_valid;
    assign fifo.wdata         = pixel_mux;
    assign sensor_array_ready = fifo.wready;
    assign fifo.rready        = video_ready;
    assign video_valid        = fifo.rvalid;
    assign video_data         = fifo.rdata;

    // Registered outputs
    assign ext_sync_act       = state.ext_act;
    assign read_start         = state.read_act;
    assign genlock_act        = state.gl_act;
    assign video_clock_strobe = state.strobe;
    assign ext_sync_pending   = (state.ext_state != EXT_IDLE);
    assign genlock_pending    = state.gl_busy;

    // Source multiplexer
    always_comb
    begin
        unique case (source_t'(video_source))
            SRC_SENSOR: pixel_mux = sensor_array_data; // [RULE_07]
            SRC_RAMP:   pixel_mux = state.ramp;        // [RULE_07]
            default:    pixel_mux = constant_value;    // [RULE_07] [RULE_09]
        endcase
    end

    // Next-state logic
    always_comb
    begin
        next_state           = state;
        next_state.sync_prev = sync_in;
        next_state.gl_prev   = genlock_in;
        next_state.ext_act   = 1'b0;
        next_state.read_act  = 1'b0;
        next_state.gl_act    = 1'b0;
        ext_fire             = 1'b0;
        gl_edge              = genlock_in && !state.gl_prev;
        // Edge chosen by polarity
        sync_edge = ext_sync_rising_edge ? (sync_in && !state.sync_prev)
                                         : (!sync_in && state.sync_prev); // [RULE_02]

        // External sync sequencer, dropped outside integrate-then-read
        if (!integrate_then_read)
        begin
            next_state.ext_state = EXT_IDLE; // [RULE_08]
        end
        else
        begin
            unique case (state.ext_state)
                EXT_IDLE:
                begin
                    if (sync_edge && ext_sync_delay_enable)
                    begin
                        next_state.ext_state = EXT_WAIT; // [RULE_01]
                        next_state.ext_count = ext_cycles;
                    end
                    else if (sync_edge)
                    begin
                        ext_fire = 1'b1; // [RULE_01]
                    end
                end
                EXT_WAIT:
                begin
                    if (state.ext_count == COUNT_ZERO)
                    begin
                        ext_fire = 1'b1;
                    end
                    else
                    begin
                        next_state.ext_count = state.ext_count - COUNT_ONE; // [RULE_01]
                    end
                end
                READ_WAIT:
                begin
                    if (state.ext_count == COUNT_ZERO)
                    begin
                        next_state.read_act  = 1'b1; // [RULE_05]
                        next_state.ext_state = EXT_IDLE;
                    end
                    else
                    begin
                        next_state.ext_count = state.ext_count - COUNT_ONE;
                    end
                end
                default:
                begin
                    next_state.ext_state = EXT_IDLE;
                end
            endcase
            // Act on sync, then optional integrate-then-read delay
            if (ext_fire)
            begin
                next_state.ext_act = 1'b1;
                if (read_delay_enable)
                begin
                    next_state.ext_state = READ_WAIT; // [RULE_05]
                    next_state.ext_count = read_cycles;
                end
                else
                begin
                    next_state.ext_state = EXT_IDLE;
                    next_state.read_act  = 1'b1; // [RULE_05]
                end
            end
        end

        // Genlock path; delay is never bypassed
        if (!genlock_enable)
        begin
            next_state.gl_busy = 1'b0; // [RULE_03]
        end
        else if (!state.gl_busy)
        begin
            if (gl_edge)
            begin
                next_state.gl_busy  = 1'b1; // [RULE_04]
                next_state.gl_count = gl_cycles;
            end
        end
        else if (state.gl_count == COUNT_ZERO)
        begin
            next_state.gl_act  = 1'b1; // [RULE_04]
            next_state.gl_busy = 1'b0;
        end
        else
        begin
            next_state.gl_count = state.gl_count - COUNT_ONE;
        end

        // Display clock source
        master_tick          = (state.div_count == DIV_LAST);
        next_state.div_count = master_tick ? '0 : state.div_count + DIV_ONE;
        next_state.strobe    = display_clock_genlock ? gl_edge : master_tick; // [RULE_06]

        // Ramp advances one count per ramp pixel, wrapping
        if (push && source_t'(video_source) == SRC_RAMP)
        begin
            next_state.ramp = state.ramp + RAMP_ONE; // [RULE_09]
        end
    end

    // State register
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    sequence s_ext_idle_mode;
        state.ext_state == EXT_IDLE && integrate_then_read;
    endsequence

    sequence s_ext_fire;
        ext_fire && integrate_then_read;
    endsequence

    property p_rise_direct;
        s_ext_idle_mode ##0 (!ext_sync_delay_enable && ext_sync_rising_edge && $rose(sync_in)) |=> ext_sync_act;
    endproperty
    a_rise_direct: assert property (p_rise_direct) else $error("rising sync not acted on"); // [RULE_02]

    property p_fall_ignored;
        s_ext_idle_mode ##0 (!ext_sync_rising_edge && $rose(sync_in)) |=> !ext_sync_act;
    endproperty
    a_fall_ignored: assert property (p_fall_ignored) else $error("wrong sync edge acted on"); // [RULE_02]

    property p_ext_delay_load;
        s_ext_idle_mode ##0 (sync_edge && ext_sync_delay_enable)
            |=> state.ext_state == EXT_WAIT && state.ext_count == $past(ext_cycles) && !ext_sync_act;
    endproperty
    a_ext_delay_load: assert property (p_ext_delay_load) else $error("sync delay not loaded"); // [RULE_01]

    property p_ext_wait_hold;
        (integrate_then_read && state.ext_state == EXT_WAIT && state.ext_count != COUNT_ZERO)
            |=> !ext_sync_act && state.ext_count == $past(state.ext_count) - COUNT_ONE;
    endproperty
    a_ext_wait_hold: assert property (p_ext_wait_hold) else $error("sync acted before delay"); // [RULE_01]

    property p_mode_ignore;
        !integrate_then_read |=> state.ext_state == EXT_IDLE && !ext_sync_act;
    endproperty
    a_mode_ignore: assert property (p_mode_ignore) else $error("sync used outside mode"); // [RULE_08]

    property p_read_direct;
        s_ext_fire ##0 !read_delay_enable |=> read_start && ext_sync_act;
    endproperty
    a_read_direct: assert property (p_read_direct) else $error("start delayed without option"); // [RULE_05]

    property p_read_delay;
        s_ext_fire ##0 read_delay_enable
            |=> ext_sync_act && !read_start && state.ext_state == READ_WAIT && state.ext_count == $past(read_cycles);
    endproperty
    a_read_delay: assert property (p_read_delay) else $error("optional delay not applied"); // [RULE_05]

    property p_gl_off;
        !genlock_enable |=> !genlock_pending && !genlock_act;
    endproperty
    a_gl_off: assert property (p_gl_off) else $error("genlock active while disabled"); // [RULE_03]

    property p_gl_delay;
        (genlock_enable && !state.gl_busy && $rose(genlock_in))
            |=> genlock_pending && !genlock_act && state.gl_count == $past(gl_cycles);
    endproperty
    a_gl_delay: assert property (p_gl_delay) else $error("genlock delay bypassed"); // [RULE_04]

    property p_gl_expire;
        (genlock_enable && state.gl_busy && state.gl_count == COUNT_ZERO) |=> genlock_act ##1 !genlock_act;
    endproperty
    a_gl_expire: assert property (p_gl_expire) else $error("genlock action missing"); // [RULE_04]

    property p_strobe_genlock;
        (display_clock_genlock && $rose(genlock_in)) |=> video_clock_strobe;
    endproperty
    a_strobe_genlock: assert property (p_strobe_genlock) else $error("genlock clock edge lost"); // [RULE_06]

    property p_strobe_master;
        (!display_clock_genlock && !master_tick) |=> !video_clock_strobe;
    endproperty
    a_strobe_master: assert property (p_strobe_master) else $error("stray master clock strobe"); // [RULE_06]

    property p_ramp_step;
        (push && video_source == SRC_RAMP) |=> state.ramp == $past(state.ramp) + RAMP_ONE;
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("ramp did not step"); // [RULE_09]

    property p_ramp_hold;
        (video_source != SRC_RAMP) |=> state.ramp == $past(state.ramp);
    endproperty
    a_ramp_hold: assert property (p_ramp_hold) else $error("ramp moved off ramp source"); // [RULE_07]
endmodule
